// file: hw/sps_pkg.sv
package sps_pkg;
    // Command encodings on {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] SPS_CMD_MRS     = 3'h0;
    localparam logic [2:0] SPS_CMD_REF     = 3'h1;
    localparam logic [2:0] SPS_CMD_PRE     = 3'h2;
    localparam logic [2:0] SPS_CMD_ACT     = 3'h3;
    localparam logic [2:0] SPS_CMD_WR      = 3'h4;
    localparam logic [2:0] SPS_CMD_RD      = 3'h5;
    localparam logic [2:0] SPS_CMD_ZQ      = 3'h6;
    localparam logic [2:0] SPS_CMD_NOP     = 3'h7;
    // Timing counts in clock_cycle_count units (plain defaults)
    localparam int SPS_MODE_SET_CMD_DELAY          = 4;
    localparam int SPS_MODE_UPDATE_DELAY           = 12;
    localparam int SPS_MIN_CLOCK_ENABLE_PULSE      = 3;
    localparam int SPS_SELF_REFRESH_EXIT_DELAY     = 16;
    localparam int SPS_SELF_REFRESH_EXIT_DLL_DELAY = 512;
    localparam int SPS_WRITE_AFTER_SRX             = 512;
    localparam int SPS_POWER_DOWN_EXIT_DELAY       = 3;
    localparam int SPS_BURST_LEN                   = 4;
    localparam int SPS_PRECHARGE_PERIOD            = 4;
    localparam int SPS_REFRESH_CYCLE_TIME          = 20;
    localparam int SPS_CNT_W                       = 10;
    typedef enum logic [2:0] {
        SPS_IDLE,
        SPS_ACTIVE,
        SPS_PD_PRE,
        SPS_PD_ACT,
        SPS_SELF_REF
    } sps_state_t;
endpackage

// file: hw/sps_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sps_link_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic on_die_termination;
    modport device (input cke, input cs_n, input ras_n, input cas_n, input we_n, input on_die_termination);
    modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output on_die_termination);
endinterface
`default_nettype wire

// file: hw/sps_device.sv
// Contract
// RULE_01: Act on cke now, cke before, command, state
// RULE_02: Controller lowers cke after mode delays
// RULE_03: Controller holds cke for minimum pulse
// RULE_04: Power-down entry/exit only with nop/deselect
// RULE_05: Self-refresh exit only with nop/deselect
// RULE_06: Self refresh entered only from idle
// RULE_07: No self refresh during read/write
// RULE_08: Banks closed picks precharge else active power-down
// RULE_09: No refresh while powered down
// RULE_10: Low cke holds state, ignores commands
// RULE_11: Only nop/deselect during self-refresh exit delay
// RULE_12: No read until dll exit delay
// RULE_13: No write for 512 cycles after exit
// RULE_14: Termination ignored, unavailable in self refresh
// RULE_15: Idle needs banks closed, no burst, delays done
// RULE_16: Controller avoids illegal combinations
// RULE_17: Decode cs, ras, cas, we, cke at edge
// RULE_18: Deselect behaves as no-operation
// RULE_19: Self-refresh exit starts on cke high
// RULE_20: Registered previous cke and state register
`timescale 1ns/10ps
`default_nettype none
module sps_device
    import sps_pkg::*;
(
    input  wire logic     clk_sys_in,
    input  wire logic     resetn_in,
    sps_link_if.device    link,
    output logic [2:0]    state_out,
    output logic          idle_out,
    output logic          odt_active_out,
    output logic          refresh_pulse_out,
    output logic          illegal_out
);
    sps_state_t           state_r;
    sps_state_t           state_nxt;
    logic                 cke_prev_r;
    logic [SPS_CNT_W-1:0] busy_r;
    logic [SPS_CNT_W-1:0] busy_nxt;
    logic                 banks_open_r;
    logic                 banks_open_nxt;
    logic                 is_nop;
    logic [2:0]           cmd;
    logic                 refresh_nxt;
    logic                 illegal_nxt;

    // Deselect folds onto no-operation
    assign is_nop = link.cs_n || ({link.ras_n, link.cas_n, link.we_n} == SPS_CMD_NOP); // RULE_18 RULE_17
    assign cmd    = link.cs_n ? SPS_CMD_NOP : {link.ras_n, link.cas_n, link.we_n};    // RULE_17

    always_comb begin
        state_nxt      = state_r;
        busy_nxt       = (busy_r != '0) ? busy_r - 1'b1 : busy_r;
        banks_open_nxt = banks_open_r;
        refresh_nxt    = 1'b0;
        illegal_nxt    = 1'b0;
        case (state_r) // RULE_01
            SPS_PD_PRE, SPS_PD_ACT: begin
                if (link.cke) begin // RULE_10 RULE_09
                    if (is_nop) begin // RULE_04
                        state_nxt = banks_open_r ? SPS_ACTIVE : SPS_IDLE;
                        busy_nxt  = SPS_CNT_W'(SPS_POWER_DOWN_EXIT_DELAY);
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
            end
            SPS_SELF_REF: begin
                if (link.cke) begin // RULE_19 RULE_10
                    if (is_nop) begin // RULE_05
                        state_nxt = SPS_IDLE;
                        busy_nxt  = SPS_CNT_W'(SPS_SELF_REFRESH_EXIT_DELAY);
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end
            end
            default: begin
                if (cke_prev_r && !link.cke) begin
                    if (is_nop) begin // RULE_04 RULE_08
                        state_nxt = banks_open_r ? SPS_PD_ACT : SPS_PD_PRE;
                    end else if (cmd == SPS_CMD_REF && state_r == SPS_IDLE && busy_r == '0) begin // RULE_06
                        state_nxt = SPS_SELF_REF;
                    end else begin
                        illegal_nxt = 1'b1;
                    end
                end else if (cke_prev_r && link.cke) begin
                    case (cmd)
                        SPS_CMD_ACT: begin
                            banks_open_nxt = 1'b1;
                            state_nxt      = SPS_ACTIVE;
                        end
                        SPS_CMD_PRE: begin
                            banks_open_nxt = 1'b0;
                            state_nxt      = SPS_IDLE;
                            busy_nxt       = SPS_CNT_W'(SPS_PRECHARGE_PERIOD);
                        end
                        SPS_CMD_RD, SPS_CMD_WR: begin
                            busy_nxt = SPS_CNT_W'(SPS_BURST_LEN);
                        end
                        SPS_CMD_REF: begin
                            refresh_nxt = 1'b1;
                            busy_nxt    = SPS_CNT_W'(SPS_REFRESH_CYCLE_TIME);
                        end
                        SPS_CMD_MRS: begin
                            busy_nxt = SPS_CNT_W'(SPS_MODE_UPDATE_DELAY);
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase
    end

    // Power state, one step per edge
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_r <= SPS_IDLE;
        end else begin
            state_r <= state_nxt; // RULE_20
        end
    end

    // Reset value low, so clock enable low after reset is not read as a power-down entry
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cke_prev_r <= 1'b0;
        end else begin
            cke_prev_r <= link.cke; // RULE_20
        end
    end

    // One shared counter for every pending delay; the latest load overwrites it
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            busy_r <= '0;
        end else begin
            busy_r <= busy_nxt;
        end
    end

    // Single flag stands for all banks; no per-bank tracking
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            banks_open_r <= 1'b0;
        end else begin
            banks_open_r <= banks_open_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            state_out <= 3'h0;
        end else begin
            state_out <= state_nxt;
        end
    end

    // Idle only once the shared delay counter is spent and clock enable is high
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            idle_out <= 1'b0;
        end else begin
            idle_out <= (state_nxt == SPS_IDLE) && !banks_open_nxt && (busy_nxt == '0) && link.cke; // RULE_15
        end
    end

    // Termination only gates the pad, never the state choice
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            odt_active_out <= 1'b0;
        end else begin
            odt_active_out <= link.on_die_termination && (state_nxt != SPS_SELF_REF); // RULE_14
        end
    end

    // Refresh can only pulse from the normal branch, never in power-down
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            refresh_pulse_out <= 1'b0;
        end else begin
            refresh_pulse_out <= refresh_nxt; // RULE_09
        end
    end

    // Bad commands are flagged but otherwise dropped
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            illegal_out <= 1'b0;
        end else begin
            illegal_out <= illegal_nxt;
        end
    end
endmodule
`default_nettype wire

// file: hw/sps_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sps_ctrl
    import sps_pkg::*;
(
    input  wire logic     clk_sys_in,
    input  wire logic     resetn_in,
    input  wire logic     req_valid_in,
    input  wire logic [2:0] req_cmd_in,
    input  wire logic     req_cke_in,
    input  wire logic     req_odt_in,
    output logic          req_ready_out,
    output logic          in_self_ref_out,
    sps_link_if.ctrl      link
);
    logic [SPS_CNT_W-1:0] hold_r;
    logic [SPS_CNT_W-1:0] xs_r;
    logic [SPS_CNT_W-1:0] dll_r;
    logic [SPS_CNT_W-1:0] wr_r;
    logic [SPS_CNT_W-1:0] mode_r;
    logic                 busy_rw_r;
    logic                 ok;
    logic                 cke_chg;
    logic                 is_nop;

    assign is_nop  = (req_cmd_in == SPS_CMD_NOP);
    assign cke_chg = (req_cke_in != link.cke);
    always_comb begin
        ok = 1'b1;
        if (cke_chg && hold_r != '0) ok = 1'b0;                               // RULE_03
        if (cke_chg && !req_cke_in && mode_r != '0) ok = 1'b0;                // RULE_02
        if (cke_chg && !is_nop && !(!req_cke_in && req_cmd_in == SPS_CMD_REF)) ok = 1'b0; // RULE_04 RULE_05 RULE_16
        if (!req_cke_in && req_cmd_in == SPS_CMD_REF && busy_rw_r) ok = 1'b0; // RULE_07
        if (xs_r != '0 && !is_nop) ok = 1'b0;                                 // RULE_11
        if (dll_r != '0 && req_cmd_in == SPS_CMD_RD) ok = 1'b0;               // RULE_12
        if (dll_r != '0 && req_odt_in) ok = 1'b0;                             // RULE_12
        if (wr_r != '0 && req_cmd_in == SPS_CMD_WR) ok = 1'b0;                // RULE_13
        if (!link.cke && !req_cke_in && !is_nop) ok = 1'b0;                   // RULE_16
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            link.cke  <= 1'b0;
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            link.on_die_termination  <= 1'b0;
            req_ready_out <= 1'b0;
            in_self_ref_out <= 1'b0;
            hold_r <= '0;
            xs_r <= '0;
            dll_r <= '0;
            wr_r <= '0;
            mode_r <= '0;
            busy_rw_r <= 1'b0;
        end else begin
            req_ready_out <= 1'b1;
            hold_r <= (hold_r != '0) ? hold_r - 1'b1 : hold_r;
            xs_r   <= (xs_r != '0) ? xs_r - 1'b1 : xs_r;
            dll_r  <= (dll_r != '0) ? dll_r - 1'b1 : dll_r;
            wr_r   <= (wr_r != '0) ? wr_r - 1'b1 : wr_r;
            mode_r <= (mode_r != '0) ? mode_r - 1'b1 : mode_r;
            busy_rw_r <= 1'b0;
            link.cs_n <= 1'b1;
            if (req_valid_in && ok) begin
                link.cke   <= req_cke_in;
                link.cs_n  <= is_nop;
                {link.ras_n, link.cas_n, link.we_n} <= req_cmd_in;
                link.on_die_termination   <= req_odt_in;
                busy_rw_r  <= (req_cmd_in == SPS_CMD_RD) || (req_cmd_in == SPS_CMD_WR);
                // Loaded one short; the change cycle counts, so clock enable holds the full pulse width
                if (cke_chg) hold_r <= SPS_CNT_W'(SPS_MIN_CLOCK_ENABLE_PULSE - 1); // RULE_03
                if (req_cmd_in == SPS_CMD_MRS)
                    mode_r <= SPS_CNT_W'(SPS_MODE_UPDATE_DELAY);
                if (cke_chg && !req_cke_in && req_cmd_in == SPS_CMD_REF)
                    in_self_ref_out <= 1'b1;
                if (cke_chg && req_cke_in && in_self_ref_out) begin
                    in_self_ref_out <= 1'b0;
                    xs_r  <= SPS_CNT_W'(SPS_SELF_REFRESH_EXIT_DELAY);
                    dll_r <= SPS_CNT_W'(SPS_SELF_REFRESH_EXIT_DLL_DELAY - 1);
                    wr_r  <= SPS_CNT_W'(SPS_WRITE_AFTER_SRX - 1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/sps_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sps_link_sva
    import sps_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       resetn_in,
    input  wire logic       cke,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       on_die_termination,
    input  wire logic [2:0] state_out,
    input  wire logic       idle_out,
    input  wire logic       odt_active_out,
    input  wire logic       refresh_pulse_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    wire logic       nop_w = cs_n || ({ras_n, cas_n, we_n} == SPS_CMD_NOP);
    wire logic       ref_w = !cs_n && ({ras_n, cas_n, we_n} == SPS_CMD_REF);

    a_sr_entry_state: assert property ($past(cke) && !cke && ref_w && idle_out |=> state_out == SPS_SELF_REF)
        else $error("self refresh not entered");
    a_pd_entry_pre: assert property ($past(cke) && !cke && nop_w && idle_out |=> state_out == SPS_PD_PRE)
        else $error("precharge power-down not entered");
    a_pd_entry_act: assert property ($past(cke) && !cke && nop_w && state_out == SPS_ACTIVE |=> state_out == SPS_PD_ACT)
        else $error("active power-down not entered");
    a_low_cke_hold: assert property (
        !$past(cke) && !cke && state_out inside {SPS_PD_PRE, SPS_PD_ACT, SPS_SELF_REF}
        |=> $stable(state_out)) else $error("state left while clock enable low");
    a_pd_no_refresh: assert property (
        state_out inside {SPS_PD_PRE, SPS_PD_ACT} && $past(state_out) == state_out
        |-> !refresh_pulse_out) else $error("refresh during power-down");
    a_sr_no_odt: assert property (state_out == SPS_SELF_REF && $past(state_out) == SPS_SELF_REF |-> !odt_active_out)
        else $error("termination active in self refresh");
    a_edge_cmd_nop: assert property ($rose(cke) |-> nop_w)
        else $error("command on clock enable rise");
    a_fall_cmd_legal: assert property ($fell(cke) |-> nop_w || ref_w)
        else $error("command on clock enable fall");
    a_srx_quiet: assert property (state_out == SPS_SELF_REF && $rose(cke) |=> nop_w [*8] ##1 nop_w [*7])
        else $error("command during self refresh exit delay");
    a_cke_min_pulse: assert property ($changed(cke) |=> $stable(cke))
        else $error("clock enable pulse too short");
    a_idle_needs_cke: assert property (idle_out |-> state_out == SPS_IDLE && $past(cke))
        else $error("idle flagged wrongly");
endmodule
`default_nettype wire

// file: bench/test_sdram_power_state_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_sdram_power_state_control
    import sps_pkg::*;
;
    logic       clk_sys_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic       req_valid_in = 1'b0;
    logic [2:0] req_cmd_in = SPS_CMD_NOP;
    logic       req_cke_in = 1'b0;
    logic       req_odt_in = 1'b0;
    logic       req_ready_out;
    logic       in_self_ref_out;
    logic [2:0] state_out;
    logic       idle_out;
    logic       odt_active_out;
    logic       refresh_pulse_out;
    int         error_cnt = 0;
    int         checks = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    sps_link_if sps_link_if_inst ();
    sps_ctrl sps_ctrl_inst (.clk_sys_in, .resetn_in, .req_valid_in, .req_cmd_in, .req_cke_in, .req_odt_in,
        .req_ready_out, .in_self_ref_out, .link(sps_link_if_inst));
    sps_device sps_device_inst (.clk_sys_in, .resetn_in, .link(sps_link_if_inst), .state_out, .idle_out,
        .odt_active_out, .refresh_pulse_out, .illegal_out());
    sps_link_sva sps_link_sva_inst (.clk_sys_in, .resetn_in, .cke(sps_link_if_inst.cke),
        .cs_n(sps_link_if_inst.cs_n), .ras_n(sps_link_if_inst.ras_n), .cas_n(sps_link_if_inst.cas_n),
        .we_n(sps_link_if_inst.we_n), .on_die_termination(sps_link_if_inst.on_die_termination), .state_out, .idle_out, .odt_active_out,
        .refresh_pulse_out);

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            #1;
        end
    endtask

    // Bounded wait; a missed state ends the run, a missed idle only counts a mismatch
    task automatic wait_until(input int n, input logic [2:0] exp, input logic need_idle);
        for (int i = 0; i < n && !(state_out === exp && (idle_out === 1'b1 || !need_idle)); i++) tick(1);
        chk(state_out === exp && (idle_out === 1'b1 || !need_idle), "expected state not reached");
        if (state_out !== exp) final_report();
    endtask

    // Extra idle cycle keeps valid from toggling twice in one step
    task automatic req(input logic [2:0] cmd, input logic cke, input logic on_die_termination);
        for (int i = 0; i < 40 && req_ready_out !== 1'b1; i++) tick(1);
        chk(req_ready_out === 1'b1, "controller not ready");
        if (req_ready_out !== 1'b1) final_report();
        req_valid_in = 1'b1;
        req_cmd_in = cmd;
        req_cke_in = cke;
        req_odt_in = on_die_termination;
        tick(1);
        req_valid_in = 1'b0;
        tick(1);
    endtask

    // Request that the controller must drop: link stays as it was
    task automatic probe(input logic [2:0] cmd, input logic cke, input logic on_die_termination, input string msg);
        req_valid_in = 1'b1;
        req_cmd_in = cmd;
        req_cke_in = cke;
        req_odt_in = on_die_termination;
        tick(1);
        chk(sps_link_if_inst.cs_n === 1'b1 && sps_link_if_inst.cke === 1'b1 && sps_link_if_inst.on_die_termination === 1'b0, msg);
        req_valid_in = 1'b0;
        tick(1);
    endtask

    task automatic t_start();
        chk(idle_out === 1'b0, "idle with clock enable low");
        req(SPS_CMD_NOP, 1'b1, 1'b0);
        wait_until(64, SPS_IDLE, 1'b1);
        $display("test start done");
    endtask

    task automatic t_pd_pre();
        req(SPS_CMD_NOP, 1'b0, 1'b0);
        wait_until(4, SPS_PD_PRE, 1'b0);
        tick(1);
        chk(idle_out === 1'b0, "idle in power-down");
        tick(SPS_MIN_CLOCK_ENABLE_PULSE);
        req(SPS_CMD_ACT, 1'b0, 1'b0);
        tick(2);
        chk(state_out === SPS_PD_PRE, "command acted on in power-down");
        req(SPS_CMD_NOP, 1'b1, 1'b0);
        wait_until(16, SPS_IDLE, 1'b1);
        $display("test precharge power-down done");
    endtask

    task automatic t_pd_act();
        req(SPS_CMD_ACT, 1'b1, 1'b0);
        wait_until(4, SPS_ACTIVE, 1'b0);
        tick(SPS_MIN_CLOCK_ENABLE_PULSE);
        req(SPS_CMD_NOP, 1'b0, 1'b0);
        wait_until(4, SPS_PD_ACT, 1'b0);
        tick(SPS_MIN_CLOCK_ENABLE_PULSE);
        req(SPS_CMD_NOP, 1'b1, 1'b0);
        wait_until(16, SPS_ACTIVE, 1'b0);
        req(SPS_CMD_PRE, 1'b1, 1'b0);
        wait_until(SPS_PRECHARGE_PERIOD + 16, SPS_IDLE, 1'b1);
        $display("test active power-down done");
    endtask

    task automatic t_refused();
        req(SPS_CMD_ACT, 1'b0, 1'b0);
        tick(2);
        chk(sps_link_if_inst.cke === 1'b1 && state_out === SPS_IDLE, "bad entry accepted");
        $display("test refused entry done");
    endtask

    task automatic t_self_ref();
        tick(SPS_MIN_CLOCK_ENABLE_PULSE);
        req(SPS_CMD_REF, 1'b0, 1'b0);
        wait_until(4, SPS_SELF_REF, 1'b0);
        chk(in_self_ref_out === 1'b1, "controller unaware of self refresh");
        req(SPS_CMD_NOP, 1'b0, 1'b1);
        tick(2);
        chk(odt_active_out === 1'b0 && state_out === SPS_SELF_REF, "termination in self refresh");
        req(SPS_CMD_NOP, 1'b1, 1'b0);
        req(SPS_CMD_RD, 1'b1, 1'b0);
        wait_until(SPS_SELF_REFRESH_EXIT_DELAY + 16, SPS_IDLE, 1'b1);
        chk(in_self_ref_out === 1'b0, "controller still in self refresh");
        tick(2);
        probe(SPS_CMD_RD, 1'b1, 1'b0, "read inside relock delay");
        probe(SPS_CMD_NOP, 1'b1, 1'b1, "termination inside relock delay");
        probe(SPS_CMD_WR, 1'b1, 1'b0, "write too soon after exit");
        req(SPS_CMD_MRS, 1'b1, 1'b0);
        probe(SPS_CMD_NOP, 1'b0, 1'b0, "clock enable low inside mode delay");
        $display("test self refresh done");
    endtask

    initial begin
        tick(2);
        resetn_in = 1'b1;
        tick(1);
        t_start();
        t_refused();
        t_pd_pre();
        t_pd_act();
        t_self_ref();
        final_report();
    end
endmodule
`default_nettype wire
